// [rtl/bph_top.sv]
// Boot memories and fetch-hold sequencing for the enclave and the external subsystem.
// Functional notes
// R1: Enclave boot ROM is writable dual-port memory.
// R2: Enclave ROM powers up with default image.
// R3: Debug reaches enclave ROM.
// R4: Built-in image loads ROM without preload.
// R5: Controller holds enclave reset and fetch-hold.
// R6: Controller releases reset, then fetch-hold.
// R7: Subsystem boots from preloadable dual-port RAM.
// R8: Subsystem RAM powers up with default image.
// R9: Debug reaches subsystem RAM; image preloads it.
// R10: Controller holds enclave fetch-hold during preload.
// R11: Subsystem fetch-hold resets asserted.
// R12: Software alone releases subsystem fetch-hold.
// R13: No fetch while fetch-hold asserted.
`timescale 1ns/1ps
`include "bph_defs.svh"
module bph_top import bph_pkg::*; #(
  parameter int ROM_AW = `BPH_ROM_AW,
  parameter int RAM_AW = `BPH_RAM_AW,
  parameter int DW = `BPH_DW,
  parameter logic [DW-1:0] ROM_FILL = '0,
  parameter logic [DW-1:0] RAM_FILL = '0
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Controller pins, asynchronous to mclk_i.
  input wire logic enc_rst_pin_i,
  input wire logic enc_hold_pin_i,
  // Controller preload/debug port: enclave ROM.
  input wire logic rom_pl_en_i,
  input wire logic rom_pl_we_i,
  input wire logic [ROM_AW-1:0] rom_pl_addr_i,
  input wire logic [DW-1:0] rom_pl_wdata_i,
  output logic [DW-1:0] rom_pl_rdata_o,
  // Controller preload/debug port: subsystem code RAM.
  input wire logic ram_pl_en_i,
  input wire logic ram_pl_we_i,
  input wire logic [RAM_AW-1:0] ram_pl_addr_i,
  input wire logic [DW-1:0] ram_pl_wdata_i,
  output logic [DW-1:0] ram_pl_rdata_o,
  // Enclave fetch port.
  input wire logic enc_fetch_req_i,
  input wire logic [ROM_AW-1:0] enc_fetch_addr_i,
  output logic [DW-1:0] enc_fetch_data_o,
  // Subsystem fetch/data port.
  input wire logic ext_fetch_req_i,
  input wire logic ext_fetch_we_i,
  input wire logic [RAM_AW-1:0] ext_fetch_addr_i,
  input wire logic [DW-1:0] ext_fetch_wdata_i,
  output logic [DW-1:0] ext_fetch_data_o,
  // Software release of the subsystem fetch-hold (same clock).
  input wire logic ext_hold_clr_i,
  output logic enc_rst_o,
  output logic enc_core_fetch_hold_o,
  output logic ext_core_fetch_hold_o,
  output logic [1:0] enc_state_o
);
  if (ROM_AW < 1 || RAM_AW < 1 || DW < 8) begin : g_bad_geometry
    $error("bph_top: unsupported memory geometry");
  end

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] hold_sync;
    logic ext_hold;
    bph_state_t st;
  } bph_regs_t;

  bph_regs_t cur_ff;
  bph_regs_t nxt_ff;

  // ----------------------------------------------------------------
  // Enclave and subsystem sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.rst_sync = {cur_ff.rst_sync[0], enc_rst_pin_i};
    nxt_ff.hold_sync = {cur_ff.hold_sync[0], enc_hold_pin_i};
    if (ext_hold_clr_i) begin
      nxt_ff.ext_hold = `BPH_ZERO; // R12
    end
    case (cur_ff.st)
      BPH_ST_RESET: begin
        if (!cur_ff.rst_sync[1]) begin
          nxt_ff.st = BPH_ST_WAIT;
        end
      end
      BPH_ST_WAIT: begin
        if (cur_ff.rst_sync[1]) begin
          nxt_ff.st = BPH_ST_RESET;
        end else if (!cur_ff.hold_sync[1]) begin
          nxt_ff.st = BPH_ST_RUN; // R6
        end
      end
      BPH_ST_RUN: begin
        if (cur_ff.rst_sync[1]) begin
          nxt_ff.st = BPH_ST_RESET;
        end else if (cur_ff.hold_sync[1]) begin
          nxt_ff.st = BPH_ST_WAIT;
        end
      end
      default: begin
        nxt_ff.st = BPH_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur_ff.rst_sync <= {2{`BPH_ONE}}; // R5
      cur_ff.hold_sync <= {2{`BPH_ONE}}; // R10
      cur_ff.ext_hold <= `BPH_ONE; // R11
      cur_ff.st <= BPH_ST_RESET;
    end else if (ce_i) begin
      cur_ff <= nxt_ff;
    end
  end

  assign enc_rst_o = cur_ff.st == BPH_ST_RESET;
  assign enc_core_fetch_hold_o = cur_ff.st != BPH_ST_RUN;
  assign ext_core_fetch_hold_o = cur_ff.ext_hold;
  assign enc_state_o = cur_ff.st;

  // ----------------------------------------------------------------
  // Boot memories
  // ----------------------------------------------------------------
  bph_mem_if #(.AW(ROM_AW), .DW(DW)) rom_bus ();
  bph_mem_if #(.AW(RAM_AW), .DW(DW)) ram_bus ();

  assign rom_bus.a_en = enc_fetch_req_i && !enc_core_fetch_hold_o; // R13
  assign rom_bus.a_we = `BPH_ZERO;
  assign rom_bus.a_addr = enc_fetch_addr_i;
  assign rom_bus.a_wdata = '0;
  assign rom_bus.b_en = rom_pl_en_i; // R1 R3
  assign rom_bus.b_we = rom_pl_we_i;
  assign rom_bus.b_addr = rom_pl_addr_i;
  assign rom_bus.b_wdata = rom_pl_wdata_i;
  assign enc_fetch_data_o = rom_bus.a_rdata;
  assign rom_pl_rdata_o = rom_bus.b_rdata;

  assign ram_bus.a_en = ext_fetch_req_i && !ext_core_fetch_hold_o; // R13
  assign ram_bus.a_we = ext_fetch_we_i;
  assign ram_bus.a_addr = ext_fetch_addr_i;
  assign ram_bus.a_wdata = ext_fetch_wdata_i;
  assign ram_bus.b_en = ram_pl_en_i; // R7 R9
  assign ram_bus.b_we = ram_pl_we_i;
  assign ram_bus.b_addr = ram_pl_addr_i;
  assign ram_bus.b_wdata = ram_pl_wdata_i;
  assign ext_fetch_data_o = ram_bus.a_rdata;
  assign ram_pl_rdata_o = ram_bus.b_rdata;

  // Built-in images stand in when no preload happens.
  bph_dual_port_memory #(.AW(ROM_AW), .DW(DW), .FILL(ROM_FILL)) u_rom ( // R2 R4
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .m(rom_bus.mem)
  );
  bph_dual_port_memory #(.AW(RAM_AW), .DW(DW), .FILL(RAM_FILL)) u_ram ( // R8 R9
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .m(ram_bus.mem)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rel_rst;
    enc_rst_o ##1 !enc_rst_o;
  endsequence

  // Three sampled pin levels are enough to cross the two-stage synchroniser.
  sequence s_rst_pin_low;
    (ce_i && !enc_rst_pin_i) [*3];
  endsequence

  sequence s_hold_pin_high;
    (ce_i && enc_hold_pin_i) [*3];
  endsequence

  // Release needs one more enabled edge to step from WAIT to RUN.
  sequence s_enc_release;
    (ce_i && !enc_rst_pin_i && !enc_hold_pin_i) [*4];
  endsequence

  a_hold_after_rst: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R6
    s_rel_rst |-> enc_core_fetch_hold_o)
    else $error("fetch-hold released together with reset");
  a_rst_implies_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R5
    enc_rst_o |-> enc_core_fetch_hold_o)
    else $error("enclave out of hold while in reset");
  a_ext_hold_sticky: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R12
    !ext_core_fetch_hold_o |=> !ext_core_fetch_hold_o)
    else $error("subsystem hold reasserted without reset");
  a_ext_hold_clr: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R12
    (ce_i && ext_hold_clr_i) |=> !ext_core_fetch_hold_o)
    else $error("subsystem hold not released");
  a_ext_hold_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R11
    (ext_core_fetch_hold_o && !ext_hold_clr_i) |=> ext_core_fetch_hold_o)
    else $error("subsystem hold dropped without software");
  a_no_enc_fetch: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
    enc_core_fetch_hold_o |-> !rom_bus.a_en)
    else $error("enclave fetch while held");
  a_no_ext_fetch: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
    ext_core_fetch_hold_o |-> !ram_bus.a_en)
    else $error("subsystem fetch while held");
  a_rst_pin_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R5
    (ce_i && enc_rst_pin_i) [*3] |=> enc_rst_o)
    else $error("enclave reset not following pin");

  a_rst_pin_release: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R6
    s_rst_pin_low |=> !enc_rst_o)
    else $error("enclave reset not released after pin");
  a_hold_pin_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R10
    s_hold_pin_high |=> enc_core_fetch_hold_o)
    else $error("enclave hold not following pin");
  a_hold_pin_release: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R6
    s_enc_release |=> !enc_core_fetch_hold_o)
    else $error("enclave hold not released after pins");
  a_enc_data_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
    enc_core_fetch_hold_o |=> $stable(enc_fetch_data_o))
    else $error("enclave fetch data changed while held");
  a_ext_data_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
    ext_core_fetch_hold_o |=> $stable(ext_fetch_data_o))
    else $error("subsystem fetch data changed while held");
endmodule

// [rtl/bph_defs.svh]
// Constants for the boot preload and hold sequencer.
`ifndef BPH_DEFS_SVH
`define BPH_DEFS_SVH
`define BPH_ROM_AW 14
`define BPH_RAM_AW 16
`define BPH_DW 32
`define BPH_SYNC_RST 2'h0
`define BPH_ONE 1'b1
`define BPH_ZERO 1'b0
`endif

// [rtl/bph_pkg.sv]
// Types for the boot preload and hold sequencer.
package bph_pkg;
  typedef enum logic [1:0] {BPH_ST_RESET, BPH_ST_WAIT, BPH_ST_RUN} bph_state_t;
endpackage

// [rtl/bph_mem_if.sv]
// Two-port memory access bundle.
`timescale 1ns/1ps
interface bph_mem_if #(parameter int AW = 14, parameter int DW = 32);
  logic a_en;
  logic a_we;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic b_en;
  logic b_we;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_wdata;
  logic [DW-1:0] b_rdata;
  modport user (output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
                input a_rdata, b_rdata);
  modport mem (input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
               output a_rdata, b_rdata);
endinterface

// [rtl/bph_dual_port_memory.sv]
// Dual-port memory with registered read data and a built-in default image.
`timescale 1ns/1ps
module bph_dual_port_memory #(
  parameter int AW = 14,
  parameter int DW = 32,
  parameter logic [DW-1:0] FILL = '0
) (
  input wire logic mclk_i,
  input wire logic ce_i,
  bph_mem_if.mem m
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  integer k;

  // The default boot image is part of the programming file as initial content.
  initial begin
    for (k = 0; k < (1<<AW); k = k + 1) begin
      mem_q[k] = FILL;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ce_i && m.a_en) begin
      if (m.a_we) begin
        mem_q[m.a_addr] <= m.a_wdata;
      end
      m.a_rdata <= mem_q[m.a_addr];
    end
    if (ce_i && m.b_en) begin
      if (m.b_we) begin
        mem_q[m.b_addr] <= m.b_wdata;
      end
      m.b_rdata <= mem_q[m.b_addr];
    end
  end
endmodule

// [test/bph_ctrl_model.sv]
// Board controller model: preloads the enclave ROM and sequences its reset and hold.
`timescale 1ns/1ps
module bph_ctrl_model #(
  parameter logic [13:0] ADDR = 14'h0005,
  parameter logic [31:0] WORD = 32'h12345678
) (
  input wire logic mclk_i,
  input wire logic go_i,
  output logic rst_pin_o,
  output logic hold_pin_o,
  output logic en_o,
  output logic we_o,
  output logic [13:0] addr_o,
  output logic [31:0] wdata_o,
  output logic done_o
);
  initial begin
    rst_pin_o = 1'b1;
    hold_pin_o = 1'b1;
    en_o = 1'b0;
    we_o = 1'b0;
    addr_o = ADDR;
    wdata_o = WORD;
    done_o = 1'b0;
    repeat (10) @(negedge mclk_i);
    en_o = 1'b1;
    we_o = 1'b1;
    @(negedge mclk_i);
    we_o = 1'b0;
    @(negedge mclk_i);
    en_o = 1'b0;
    addr_o = ~ADDR;
    wdata_o = ~WORD;
    done_o = 1'b1;
    for (int i = 0; i < 200 && go_i !== 1'b1; i++) begin
      @(negedge mclk_i);
    end
    @(negedge mclk_i);
    rst_pin_o = 1'b0;
    repeat (6) @(negedge mclk_i);
    hold_pin_o = 1'b0;
  end
endmodule

// [test/bph_top_tb_top.sv]
// Self-checking bench for the boot preload and hold sequencer.
`timescale 1ns/1ps
module bph_top_tb_top import bph_pkg::*;;
  localparam logic [31:0] ROMF = 32'h5EED0000;
  localparam logic [31:0] RAMF = 32'hFACE0000;
  localparam logic [31:0] WD = 32'hC0DE0001;
  localparam logic [31:0] XD = 32'h0BADF00D;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic go = 1'b0, xen = 1'b0, xwe = 1'b0, efr = 1'b0, xfr = 1'b0, xfwe = 1'b0, clr = 1'b0;
  logic ce = 1'b1;
  logic done, rp, hp, ren, rwe, erst, ehold, xhold;
  logic [1:0] st;
  logic [13:0] ra, efa = '0;
  logic [15:0] xa = '0, xfa = '0;
  logic [31:0] rw, rr, xw = '0, xr, efd, xfw = '0, xfd;
  int bad_count = 0;
  int n_compared = 0;
  bph_ctrl_model #(.ADDR(14'h0005), .WORD(WD)) ctrl (.mclk_i(mclk_i), .go_i(go),
    .rst_pin_o(rp), .hold_pin_o(hp), .en_o(ren), .we_o(rwe), .addr_o(ra), .wdata_o(rw),
    .done_o(done));
  bph_top #(.ROM_FILL(ROMF), .RAM_FILL(RAMF)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce), .enc_rst_pin_i(rp), .enc_hold_pin_i(hp), .rom_pl_en_i(ren),
    .rom_pl_we_i(rwe), .rom_pl_addr_i(ra), .rom_pl_wdata_i(rw), .rom_pl_rdata_o(rr),
    .ram_pl_en_i(xen), .ram_pl_we_i(xwe), .ram_pl_addr_i(xa), .ram_pl_wdata_i(xw),
    .ram_pl_rdata_o(xr), .enc_fetch_req_i(efr), .enc_fetch_addr_i(efa),
    .enc_fetch_data_o(efd), .ext_fetch_req_i(xfr), .ext_fetch_we_i(xfwe),
    .ext_fetch_addr_i(xfa), .ext_fetch_wdata_i(xfw), .ext_fetch_data_o(xfd),
    .ext_hold_clr_i(clr), .enc_rst_o(erst), .enc_core_fetch_hold_o(ehold),
    .ext_core_fetch_hold_o(xhold), .enc_state_o(st));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic ram_acc(input logic we, input logic [15:0] a, input logic [31:0] d);
    xen = 1'b1;
    xwe = we;
    xa = a;
    xw = d;
    cyc(1);
    xen = 1'b0;
    xa = ~a;
    xw = ~d;
    cyc(1);
  endtask
  task automatic enc_f(input logic [13:0] a);
    efr = 1'b1;
    efa = a;
    cyc(1);
    efr = 1'b0;
    cyc(1);
  endtask
  task automatic ext_f(input logic we, input logic [15:0] a, input logic [31:0] d);
    xfr = 1'b1;
    xfwe = we;
    xfa = a;
    xfw = d;
    cyc(1);
    xfr = 1'b0;
    xfw = ~d;
    cyc(1);
  endtask
  task automatic t_reset();
    chk({31'h0, erst}, 32'h1);
    chk({31'h0, ehold}, 32'h1);
    chk({31'h0, xhold}, 32'h1);
    chk({30'h0, st}, 32'(BPH_ST_RESET));
    $display("test reset done");
  endtask
  task automatic t_enc();
    logic [31:0] old;
    for (int i = 0; i < 50 && done !== 1'b1; i++) begin
      cyc(1);
    end
    if (done !== 1'b1) begin
      bad_count++;
      return;
    end
    chk(rr, WD);
    go = 1'b1;
    cyc(6);
    chk({31'h0, erst}, 32'h0);
    chk({30'h0, st}, 32'(BPH_ST_WAIT));
    chk({31'h0, ehold}, 32'h1);
    old = efd;
    enc_f(14'h0005);
    chk(efd, old);
    cyc(8);
    chk({31'h0, ehold}, 32'h0);
    chk({30'h0, st}, 32'(BPH_ST_RUN));
    enc_f(14'h0005);
    chk(efd, WD);
    enc_f(14'h0000);
    chk(efd, ROMF);
    $display("test enclave done");
  endtask
  task automatic t_ext();
    logic [31:0] old;
    ram_acc(1'b1, 16'h0003, XD);
    ram_acc(1'b0, 16'h0003, 32'h0);
    chk(xr, XD);
    ram_acc(1'b0, 16'h0009, 32'h0);
    chk(xr, RAMF);
    old = xfd;
    ext_f(1'b0, 16'h0003, 32'h0);
    chk(xfd, old);
    chk({31'h0, xhold}, 32'h1);
    ce = 1'b0;
    clr = 1'b1;
    cyc(2);
    chk({31'h0, xhold}, 32'h1);
    ce = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk({31'h0, xhold}, 32'h0);
    ext_f(1'b0, 16'h0003, 32'h0);
    chk(xfd, XD);
    ext_f(1'b1, 16'h0004, WD);
    ram_acc(1'b0, 16'h0004, 32'h0);
    chk(xr, WD);
    $display("test subsystem done");
  endtask
  task automatic t_rerst();
    logic [31:0] oe;
    logic [31:0] ox;
    oe = efd;
    ox = xfd;
    sys_rst_i = 1'b1;
    cyc(1);
    chk({31'h0, erst}, 32'h1);
    chk({31'h0, xhold}, 32'h1);
    chk({30'h0, st}, 32'(BPH_ST_RESET));
    enc_f(14'h0005);
    chk(efd, oe);
    ext_f(1'b0, 16'h0003, 32'h0);
    chk(xfd, ox);
    sys_rst_i = 1'b0;
    cyc(2);
    chk({31'h0, erst}, 32'h1);
    chk({31'h0, ehold}, 32'h1);
    cyc(8);
    chk({31'h0, ehold}, 32'h0);
    chk({30'h0, st}, 32'(BPH_ST_RUN));
    chk({31'h0, xhold}, 32'h1);
    $display("test mid-run reset done");
  endtask
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    cyc(8);
    sys_rst_i = 1'b0;
    t_reset();
    t_enc();
    t_ext();
    t_rerst();
    end_sim();
  end
endmodule
